// File: rtcirq_top.sv
// pin priority, power-on defaults and trim load of the rtc pin block
// Overview of operation
// R1: backup with backup enable clear releases shared pin high.
// R2: backup, output bit 1, no enabled alarm1/osc-fail: pin high.
// R3: backup, backup enable 1, output bit 0: pin driven low.
// R4: backup, out 1, enable 1, interrupts enabled: low when enabled source asserts.
// R5: in backup only alarm1 and osc-fail sources affect the pin.
// R6: frequency test output suppressed during backup.
// R7: backup enable at alarm1 month bit 5; output bit digital calib bit 7.
// R8: each source keeps its own flag in the flags register.
// R9: sources ORed; pin stays low until every source cleared.
// R10: host reads flags and services every set source.
// R11: small variant: frequency test bit gives 512 Hz on test/reset pin.
// R12: test bit 0 and supply good: test/reset pin high.
// R13: supply fails with test on: clear test bit, drive pin low.
// R14: frequency test bit is 0 at power-up.
// R15: first power-up: listed control bits 0; output and square enable 1.
// R16: first power-up: hold, osc-fail, source selects, low rate 1; others 0.
// R17: later power-ups clear test, watchdog, countdown enable; set hold flag.
// R18: lock bit set copies factory trim and makes trim register read-only.
// R19: lock bit clear: trim register is ordinary storage.
// R20: factory trim load completes about 8 ms after lock set.
// R21: osc-fail flag stays until written 0; reads do not clear it.
// R22: shared pin is open drain, pulls low only.
// R23: timer and watchdog disabled during backup.
// R24: backup indicator selects backup priority, else main priority.
`include "rtcirq_cfg.svh"
module rtcirq_top #(
  parameter int unsigned OTP_CYC = `RTCIRQ_OTP_CYC
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // power state
  input wire logic first_power_up,
  input wire logic backup_mode,
  input wire logic vcc_good,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // interrupt source events
  input wire logic alarm1_event,
  input wire logic osc_fail_event,
  input wire logic timer_event,
  input wire logic watchdog_event,
  // shared open-drain pin
  input wire logic shared_irq_output_pin_i,
  output logic shared_irq_output_pin_o,
  output logic shared_irq_output_pin_oe,
  // test or reset pin
  output logic test_or_reset_pin,
  // status
  output logic trim_busy
);
  logic [7:0] digcal_r;
  logic [7:0] wdog_r;
  logic [7:0] a1mon_r;
  logic [7:0] flags_r;
  logic [7:0] tmrctl_r;
  logic [7:0] atrim_r;
  logic [7:0] ctl_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [31:0] otp_cnt_r;
  rtcirq_pkg::rtcirq_trim_e trim_r;
  rtcirq_pkg::rtcirq_pwr_e pwr_r;
  logic test_wave;
  logic vcc_good_d_r;
  logic pin_low;
  logic out_bit, freq_test_enable, wd_run;
  logic backup_irq_enable, alarm1_irq_enable, osc_fail_irq_enable, countdown_irq_enable;
  logic src_main, src_bkp, en_main, en_bkp;
  logic wr_digcal, wr_wdog, wr_a1mon, wr_flags, wr_tmrctl, wr_atrim, wr_ctl;
  logic supply_fail;

  assign out_bit = digcal_r[`RTCIRQ_BIT_OUT];
  assign freq_test_enable = digcal_r[`RTCIRQ_BIT_FREQ_TEST];
  // R7 bit positions
  assign backup_irq_enable = a1mon_r[`RTCIRQ_BIT_BACKUP_IRQ_EN];
  assign alarm1_irq_enable = a1mon_r[`RTCIRQ_BIT_ALARM1_IRQ_EN];
  assign osc_fail_irq_enable = wdog_r[`RTCIRQ_BIT_OSC_FAIL_IRQ_EN];
  assign countdown_irq_enable = tmrctl_r[`RTCIRQ_BIT_COUNTDOWN_IRQ_EN];
  // watchdog counts as running when any multiplier or resolution bit is set
  assign wd_run = |wdog_r[6:0];

  // write strobes, frozen together with the rest of the state
  assign wr_digcal = clk_en && reg_wr && reg_addr == `RTCIRQ_OFS_DIGCAL;
  assign wr_wdog = clk_en && reg_wr && reg_addr == `RTCIRQ_OFS_WDOG;
  assign wr_a1mon = clk_en && reg_wr && reg_addr == `RTCIRQ_OFS_A1MON;
  assign wr_flags = clk_en && reg_wr && reg_addr == `RTCIRQ_OFS_FLAGS;
  assign wr_tmrctl = clk_en && reg_wr && reg_addr == `RTCIRQ_OFS_TMRCTL;
  assign wr_atrim = clk_en && reg_wr && reg_addr == `RTCIRQ_OFS_ATRIM;
  assign wr_ctl = clk_en && reg_wr && reg_addr == `RTCIRQ_OFS_CTL;
  // supply loss seen as the falling edge of the good level
  assign supply_fail = vcc_good_d_r && !vcc_good;

  // R24 power mode tracking
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwr_r <= rtcirq_pkg::RTCIRQ_PWR_MAIN;
      vcc_good_d_r <= 1'b1;
    end else if (clk_en) begin
      pwr_r <= backup_mode ? rtcirq_pkg::RTCIRQ_PWR_BACKUP : rtcirq_pkg::RTCIRQ_PWR_MAIN;
      vcc_good_d_r <= vcc_good;
    end
  end

  // digital calibration: output bit, test bit, sign, value
  always_ff @(posedge core_clk) begin
    if (srst) begin
      // R15 R17 first power-up defaults, later only test bit clears
      if (first_power_up) begin
        digcal_r <= `RTCIRQ_RST_DIGCAL;
      end else begin
        // R14 test bit 0 at power-up
        digcal_r[`RTCIRQ_BIT_FREQ_TEST] <= 1'b0;
      end
    end else if (clk_en) begin
      if (supply_fail && freq_test_enable) begin
        // R13 test bit cleared on supply failure
        digcal_r[`RTCIRQ_BIT_FREQ_TEST] <= 1'b0;
      end else if (wr_digcal) begin
        digcal_r <= reg_wdata;
      end
    end
  end

  // watchdog register: osc-fail enable and watchdog fields
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if (first_power_up) begin
        wdog_r <= `RTCIRQ_RST_WDOG;
      end else begin
        // R17 watchdog fields clear
        wdog_r[6:0] <= 7'h00;
      end
    end else if (wr_wdog) begin
      wdog_r <= reg_wdata;
    end
  end

  // alarm 1 month: alarm enable, backup enable, repeat, month
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if (first_power_up) begin
        a1mon_r <= `RTCIRQ_RST_A1MON;
      end
    end else if (wr_a1mon) begin
      a1mon_r <= reg_wdata;
    end
  end

  // timer control: countdown enable, pulse, irq enable, source select
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if (first_power_up) begin
        tmrctl_r <= `RTCIRQ_RST_TMRCTL;
      end else begin
        // R17 countdown enable clears
        tmrctl_r[7] <= 1'b0;
      end
    end else if (wr_tmrctl) begin
      tmrctl_r <= reg_wdata;
    end
  end

  // flags: per-source sticky bits, set wins over clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if (first_power_up) begin
        flags_r <= `RTCIRQ_RST_FLAGS;
      end
    end else if (clk_en) begin
      // R8 separate flag per source; R21 only a write of 0 clears
      if (wr_flags) begin
        flags_r <= flags_r & reg_wdata;
      end
      if (alarm1_event) begin
        flags_r[`RTCIRQ_BIT_ALARM1_FLAG] <= 1'b1;
      end
      if (osc_fail_event) begin
        flags_r[`RTCIRQ_BIT_OSC_FAIL_FLAG] <= 1'b1;
      end
      // R23 timer and watchdog stopped during backup
      if (timer_event && !backup_mode) begin
        flags_r[`RTCIRQ_BIT_TIMER_FLAG] <= 1'b1;
      end
      if (watchdog_event && !backup_mode) begin
        flags_r[`RTCIRQ_BIT_WDOG_FLAG] <= 1'b1;
      end
    end
  end

  // control register: lock bit, hold flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if (first_power_up) begin
        // R16 hold flag set, lock clear
        ctl_r <= `RTCIRQ_RST_CTL;
      end else begin
        // R17 hold flag sets on later power-up
        ctl_r[`RTCIRQ_BIT_HOLD_FLAG] <= 1'b1;
      end
    end else if (wr_ctl) begin
      ctl_r <= reg_wdata;
    end
  end

  // factory trim load sequencing
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trim_r <= rtcirq_pkg::RTCIRQ_TRIM_IDLE;
      otp_cnt_r <= 32'h0000_0000;
    end else if (clk_en) begin
      case (trim_r)
        rtcirq_pkg::RTCIRQ_TRIM_IDLE: begin
          otp_cnt_r <= 32'h0000_0000;
          if (ctl_r[`RTCIRQ_BIT_LOCK]) begin
            trim_r <= rtcirq_pkg::RTCIRQ_TRIM_WAIT;
          end
        end
        rtcirq_pkg::RTCIRQ_TRIM_WAIT: begin
          if (!ctl_r[`RTCIRQ_BIT_LOCK]) begin
            trim_r <= rtcirq_pkg::RTCIRQ_TRIM_IDLE;
          end else if (otp_cnt_r == OTP_CYC - 1) begin
            // R20 load after the trim read time
            trim_r <= rtcirq_pkg::RTCIRQ_TRIM_DONE;
          end else begin
            otp_cnt_r <= otp_cnt_r + 32'h0000_0001;
          end
        end
        rtcirq_pkg::RTCIRQ_TRIM_DONE: begin
          if (!ctl_r[`RTCIRQ_BIT_LOCK]) begin
            trim_r <= rtcirq_pkg::RTCIRQ_TRIM_IDLE;
          end
        end
        default: trim_r <= rtcirq_pkg::RTCIRQ_TRIM_IDLE;
      endcase
    end
  end
  assign trim_busy = trim_r == rtcirq_pkg::RTCIRQ_TRIM_WAIT;

  // analog trim register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if (first_power_up) begin
        atrim_r <= `RTCIRQ_RST_ATRIM;
      end
    end else if (clk_en) begin
      if (trim_r == rtcirq_pkg::RTCIRQ_TRIM_WAIT && otp_cnt_r == OTP_CYC - 1) begin
        // R18 factory value copied in
        atrim_r <= `RTCIRQ_FACTORY_TRIM;
      end else if (wr_atrim && !ctl_r[`RTCIRQ_BIT_LOCK]) begin
        // R19 writable while unlocked
        atrim_r <= reg_wdata;
      end
    end
  end

  // register read port, one cycle latency
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else if (clk_en) begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `RTCIRQ_OFS_DIGCAL: rdata_r <= digcal_r;
          `RTCIRQ_OFS_WDOG: rdata_r <= wdog_r;
          `RTCIRQ_OFS_A1MON: rdata_r <= a1mon_r;
          `RTCIRQ_OFS_FLAGS: rdata_r <= flags_r;
          `RTCIRQ_OFS_TMRCTL: rdata_r <= tmrctl_r;
          `RTCIRQ_OFS_ATRIM: rdata_r <= atrim_r;
          `RTCIRQ_OFS_CTL: rdata_r <= ctl_r;
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  // 512 hz test wave
  rtcirq_divider #(
    .HALF(`RTCIRQ_TEST_HALF)
  ) u_div (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .run(freq_test_enable && !backup_mode),
    .wave(test_wave)
  );

  // R5 only alarm1 and osc-fail count in backup; R9 sources ORed
  assign en_bkp = alarm1_irq_enable || osc_fail_irq_enable;
  assign src_bkp = (alarm1_irq_enable && flags_r[`RTCIRQ_BIT_ALARM1_FLAG]) ||
    (osc_fail_irq_enable && flags_r[`RTCIRQ_BIT_OSC_FAIL_FLAG]);
  assign en_main = en_bkp || countdown_irq_enable || wd_run;
  assign src_main = src_bkp || (countdown_irq_enable && flags_r[`RTCIRQ_BIT_TIMER_FLAG]) ||
    (wd_run && flags_r[`RTCIRQ_BIT_WDOG_FLAG]);

  // pin pull-down, backup priority first
  always_comb begin
    pin_low = 1'b0;
    if (pwr_r == rtcirq_pkg::RTCIRQ_PWR_BACKUP) begin
      // R6 test wave ignored in backup
      if (!backup_irq_enable) begin
        // R1 released
        pin_low = 1'b0;
      end else if (!out_bit) begin
        // R3 output bit dominates
        pin_low = 1'b1;
      end else if (!en_bkp) begin
        // R2 nothing enabled
        pin_low = 1'b0;
      end else begin
        // R4 follows enabled sources
        pin_low = src_bkp;
      end
    end else begin
      // main supply: test wave unless output bit 1 with a source enabled, then output bit, then sources
      if (freq_test_enable && (!out_bit || !en_main)) begin
        pin_low = !test_wave;
      end else if (!out_bit) begin
        pin_low = 1'b1;
      end else begin
        pin_low = en_main && src_main;
      end
    end
  end

  // R22 open drain: drive low only
  assign shared_irq_output_pin_o = 1'b0;
  assign shared_irq_output_pin_oe = pin_low;

  // R11 R12 R13 test wave or reset output
  assign test_or_reset_pin = !vcc_good ? 1'b0 : (freq_test_enable ? test_wave : 1'b1);
endmodule

// File: rtcirq_cfg.svh
// offsets, field positions, reset values and timing counts for the rtc pin block
`ifndef RTCIRQ_CFG_SVH
`define RTCIRQ_CFG_SVH
`define RTCIRQ_OFS_DIGCAL 5'h08
`define RTCIRQ_OFS_WDOG 5'h09
`define RTCIRQ_OFS_A1MON 5'h0a
`define RTCIRQ_OFS_FLAGS 5'h0f
`define RTCIRQ_OFS_TMRCTL 5'h11
`define RTCIRQ_OFS_ATRIM 5'h12
`define RTCIRQ_OFS_CTL 5'h13
`define RTCIRQ_BIT_OUT 7
`define RTCIRQ_BIT_FREQ_TEST 6
`define RTCIRQ_BIT_DCAL_SIGN 5
`define RTCIRQ_BIT_OSC_FAIL_IRQ_EN 7
`define RTCIRQ_BIT_ALARM1_IRQ_EN 7
`define RTCIRQ_BIT_BACKUP_IRQ_EN 5
`define RTCIRQ_BIT_OSC_FAIL_FLAG 2
`define RTCIRQ_BIT_WDOG_FLAG 7
`define RTCIRQ_BIT_ALARM1_FLAG 6
`define RTCIRQ_BIT_TIMER_FLAG 3
`define RTCIRQ_BIT_COUNTDOWN_IRQ_EN 5
`define RTCIRQ_BIT_LOCK 0
`define RTCIRQ_BIT_HOLD_FLAG 6
`define RTCIRQ_RST_DIGCAL 8'h80
`define RTCIRQ_RST_WDOG 8'h00
`define RTCIRQ_RST_A1MON 8'h00
`define RTCIRQ_RST_FLAGS 8'h04
`define RTCIRQ_RST_TMRCTL 8'h03
`define RTCIRQ_RST_ATRIM 8'h00
`define RTCIRQ_RST_CTL 8'h40
`define RTCIRQ_CLK_HZ 40000000
`define RTCIRQ_TEST_HZ 512
`define RTCIRQ_TEST_HALF ((`RTCIRQ_CLK_HZ) / (2 * `RTCIRQ_TEST_HZ))
`define RTCIRQ_OTP_MS 8
`define RTCIRQ_OTP_CYC ((`RTCIRQ_CLK_HZ / 1000) * `RTCIRQ_OTP_MS)
`define RTCIRQ_FACTORY_TRIM 8'h00
`endif

// File: rtcirq_pkg.sv
// types for the rtc pin block
package rtcirq_pkg;
  typedef enum logic [1:0] {
    RTCIRQ_PWR_MAIN = 2'b00,
    RTCIRQ_PWR_BACKUP = 2'b01
  } rtcirq_pwr_e;
  typedef enum logic [1:0] {
    RTCIRQ_TRIM_IDLE = 2'b00,
    RTCIRQ_TRIM_WAIT = 2'b01,
    RTCIRQ_TRIM_DONE = 2'b10
  } rtcirq_trim_e;
endpackage

// File: rtcirq_divider.sv
// square-wave divider for the frequency test output
`include "rtcirq_cfg.svh"
module rtcirq_divider #(
  parameter int unsigned HALF = `RTCIRQ_TEST_HALF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // control
  input wire logic run,
  // square wave
  output logic wave
);
  logic [15:0] cnt_r;
  logic wave_r;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_r <= 16'h0000;
      wave_r <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_r <= 16'h0000;
        wave_r <= 1'b0;
      end else if (cnt_r == 16'(HALF - 1)) begin
        cnt_r <= 16'h0000;
        wave_r <= ~wave_r;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
  assign wave = wave_r;
endmodule

// File: rtcirq_checker_assertions.sv
// port checks of the rtc pin block
module rtcirq_checker #(
  parameter int unsigned OTP_CYC = 16
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // power state
  input wire logic first_power_up,
  input wire logic vcc_good,
  // register port
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // pins and status
  input wire logic shared_irq_output_pin_o,
  input wire logic shared_irq_output_pin_oe,
  input wire logic test_or_reset_pin,
  input wire logic trim_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] busy_cnt_r;
  // length of the current trim load
  always_ff @(posedge core_clk) begin
    if (srst || !trim_busy) begin
      busy_cnt_r <= 32'h0000_0000;
    end else if (clk_en) begin
      busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  chk_rd_answer: assert property (clk_en && reg_rd |=> reg_rvalid)
    else $error("read strobe without data valid");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(clk_en && reg_rd))
    else $error("data valid without read strobe");
  chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved outside a read");
  chk_open_drain: assert property (!shared_irq_output_pin_o)
    else $error("shared pin driven high");
  chk_reset_low: assert property (!vcc_good [*2] |-> !test_or_reset_pin)
    else $error("reset pin high with supply failed");
  chk_powerup_pin: assert property ($fell(srst) && vcc_good |-> test_or_reset_pin)
    else $error("reset pin low after power-up");
  chk_first_pin: assert property ($fell(srst) && first_power_up |-> !shared_irq_output_pin_oe)
    else $error("shared pin pulled low after first power-up");
  chk_trim_max: assert property (trim_busy |-> busy_cnt_r <= OTP_CYC + 1)
    else $error("trim load too long");
  chk_trim_min: assert property ($fell(trim_busy) |-> $past(busy_cnt_r) + 2 >= OTP_CYC)
    else $error("trim load too short");
endmodule
bind rtcirq_top rtcirq_checker #(.OTP_CYC(OTP_CYC)) rtcirq_checker_inst (.core_clk(core_clk), .srst(srst),
  .clk_en(clk_en), .first_power_up(first_power_up), .vcc_good(vcc_good), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .shared_irq_output_pin_o(shared_irq_output_pin_o),
  .shared_irq_output_pin_oe(shared_irq_output_pin_oe), .test_or_reset_pin(test_or_reset_pin),
  .trim_busy(trim_busy));

// File: rtcirq_host.sv
// host processor model on the register port
module rtcirq_host (
  // clock
  input wire logic core_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
  // read flags, clear every set source
  task automatic service(output logic [7:0] f);
    rd(5'h0f, f);
    wr(5'h0f, ~f);
  endtask
endmodule

// File: rtcirq_tb.sv
// self-checking bench for the rtc pin block
`include "rtcirq_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic first_power_up = 1'b1;
  logic backup_mode = 1'b0;
  logic vcc_good = 1'b1;
  logic [3:0] evt = 4'h0;
  logic reg_wr, reg_rd, reg_rvalid, pin_o, pin_oe, pin, test_or_reset_pin, trim_busy;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int err_count = 0;
  int samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  assign pin = pin_oe ? pin_o : 1'b1;
  rtcirq_host rtcirq_host_inst (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  rtcirq_top #(.OTP_CYC(16)) rtcirq_top_inst (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .first_power_up(first_power_up), .backup_mode(backup_mode), .vcc_good(vcc_good), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .alarm1_event(evt[3]), .osc_fail_event(evt[2]), .timer_event(evt[1]), .watchdog_event(evt[0]),
    .shared_irq_output_pin_i(pin), .shared_irq_output_pin_o(pin_o), .shared_irq_output_pin_oe(pin_oe),
    .test_or_reset_pin(test_or_reset_pin), .trim_busy(trim_busy));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rtcirq_host_inst.rd(a, d);
    chk(d, exp);
  endtask
  task automatic cp(input logic exp);
    chk({7'h00, pin}, {7'h00, exp});
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    rtcirq_host_inst.wr(a, d);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(negedge core_clk);
    evt = m;
    @(negedge core_clk);
    evt = 4'h0;
  endtask
  task automatic pw(input logic fp);
    @(negedge core_clk);
    srst = 1'b1;
    first_power_up = fp;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
  endtask
  task automatic t_defaults();
    cp(1'b1);
    rc(5'h08, 8'h80);
    rc(5'h09, 8'h00);
    rc(5'h0a, 8'h00);
    rc(5'h0f, 8'h04);
    rc(5'h11, 8'h03);
    rc(5'h12, 8'h00);
    rc(5'h13, 8'h40);
    wr(5'h1f, 8'hff);
    rc(5'h1f, 8'h00);
  endtask
  task automatic t_backup();
    logic [7:0] dc [6] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'hc0, 8'h80};
    logic [7:0] wd [6] = '{8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    logic [7:0] am [6] = '{8'h80, 8'h20, 8'h20, 8'h20, 8'h20, 8'ha0};
    logic ep [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    backup_mode = 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(5'h08, dc[i]);
      wr(5'h09, wd[i]);
      wr(5'h0a, am[i]);
      @(negedge core_clk);
      cp(ep[i]);
    end
    wr(5'h08, 8'h00);
    wr(5'h0a, 8'h00);
    cp(1'b1);
    backup_mode = 1'b0;
    repeat (2) @(negedge core_clk);
    cp(1'b0);
  endtask
  task automatic t_or();
    logic [7:0] f;
    wr(5'h0f, 8'h00);
    wr(5'h08, 8'h80);
    wr(5'h09, 8'h80);
    wr(5'h0a, 8'h80);
    cp(1'b1);
    pulse(4'h4);
    cp(1'b0);
    pulse(4'h8);
    rc(5'h0f, 8'h44);
    rc(5'h0f, 8'h44);
    wr(5'h0f, 8'hfb);
    cp(1'b0);
    rtcirq_host_inst.service(f);
    chk(f, 8'h40);
    cp(1'b1);
    // timer flag left pending from main supply must not reach the pin in backup
    wr(5'h11, 8'h20);
    pulse(4'h2);
    cp(1'b0);
    wr(5'h0a, 8'ha0);
    backup_mode = 1'b1;
    repeat (2) @(negedge core_clk);
    pulse(4'h3);
    cp(1'b1);
    rc(5'h0f, 8'h08);
    pulse(4'h8);
    cp(1'b0);
    rtcirq_host_inst.service(f);
    chk(f, 8'h48);
    backup_mode = 1'b0;
  endtask
  task automatic t_trim();
    int n;
    wr(5'h12, 8'h5a);
    rc(5'h12, 8'h5a);
    wr(5'h13, 8'h01);
    // lock bit reaches the load sequencer one edge after the write
    @(negedge core_clk);
    chk({7'h00, trim_busy}, 8'h01);
    n = 0;
    while (trim_busy === 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk({7'h00, n >= 15 && n <= 17}, 8'h01);
    rc(5'h12, `RTCIRQ_FACTORY_TRIM);
    wr(5'h12, 8'h33);
    rc(5'h12, `RTCIRQ_FACTORY_TRIM);
  endtask
  task automatic t_freq();
    int n;
    logic l;
    wr(5'h08, 8'hc0);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      l = test_or_reset_pin;
      while (test_or_reset_pin === l && n < 40000) begin
        @(negedge core_clk);
        n++;
      end
    end
    chk({7'h00, n >= 39061 && n <= 39064}, 8'h01);
    vcc_good = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({7'h00, test_or_reset_pin}, 8'h00);
    rc(5'h08, 8'h80);
    vcc_good = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({7'h00, test_or_reset_pin}, 8'h01);
  endtask
  task automatic t_later();
    wr(5'h08, 8'hc0);
    wr(5'h09, 8'h85);
    wr(5'h11, 8'h83);
    pw(1'b0);
    rc(5'h08, 8'h80);
    rc(5'h09, 8'h80);
    rc(5'h11, 8'h03);
    rc(5'h13, 8'h41);
    rc(5'h12, `RTCIRQ_FACTORY_TRIM);
  endtask
  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    t_defaults();
    t_backup();
    t_or();
    t_trim();
    t_freq();
    t_later();
    wrap_up();
  end
endmodule
